/* rtl/ttbu_pkg.sv */
package ttbu_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] TTBU_OFF_CONTROL_ONE = 8'h00;
  localparam logic [7:0] TTBU_OFF_EVENT_GEN   = 8'h04;
  localparam logic [7:0] TTBU_OFF_FLAG        = 8'h08;
  localparam logic [7:0] TTBU_OFF_IRQ_EN      = 8'h0C;
  localparam logic [7:0] TTBU_OFF_COUNT       = 8'h10;
  localparam logic [7:0] TTBU_OFF_PRESCALE    = 8'h14;
  localparam logic [7:0] TTBU_OFF_RELOAD      = 8'h18;
  localparam logic [7:0] TTBU_OFF_SLAVE_MODE  = 8'h1C;

  // ==========================================================================
  // field positions: control_one bits, then bit 0 of the generate, flag and irq enable registers
  localparam int TTBU_BIT_RUN    = 0;
  localparam int TTBU_BIT_UDIS   = 1;
  localparam int TTBU_BIT_URS    = 2;
  localparam int TTBU_BIT_DIR    = 4;
  localparam int TTBU_BIT_CMS    = 5;
  localparam int TTBU_BIT_ARPE   = 7;
  localparam int TTBU_BIT_UG     = 0;
  localparam int TTBU_BIT_UFLAG  = 0;
  localparam int TTBU_BIT_UIE    = 0;

  localparam int TTBU_CNT_W = 16;
  localparam int TTBU_EXP_W = 4;
  localparam int TTBU_SMS_W = 3;

  localparam logic [TTBU_CNT_W-1:0] TTBU_RELOAD_RST = 16'hFFFF;
  localparam logic [TTBU_CNT_W-1:0] TTBU_ONE        = 16'h0001;
  localparam logic [TTBU_CNT_W-1:0] TTBU_ZERO       = 16'h0000;
  localparam logic [TTBU_SMS_W-1:0] TTBU_SMS_INTERNAL = 3'h0;

  // ==========================================================================
  // types
  typedef enum logic { TTBU_DIR_UP, TTBU_DIR_DOWN } ttbu_dir_e;

  typedef struct packed {
    logic                  reload_preload_enable;
    logic                  center_mode;
    ttbu_dir_e             count_direction;
    logic                  update_request_source;
    logic                  update_disable;
    logic                  counter_run_bit;
  } ttbu_ctrl_s;

  typedef struct packed {
    ttbu_ctrl_s            ctrl;
    logic                  counter_run_sync;
    logic                  update_flag;
    logic                  update_irq_en;
    logic [TTBU_SMS_W-1:0] slave_mode_select;
    logic [TTBU_CNT_W-1:0] count_value;
    logic [TTBU_CNT_W-1:0] reload_buf;
    logic [TTBU_CNT_W-1:0] reload_shadow;
    logic [TTBU_EXP_W-1:0] prescale_buf;
    logic [TTBU_EXP_W-1:0] prescale_work;
    logic [TTBU_CNT_W-1:0] prescale_cnt;
    logic [31:0]           prdata;
    logic                  pslverr;
  } ttbu_state_s;

endpackage : ttbu_pkg

/* rtl/ttbu_time_base.sv */
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module ttbu_time_base
  import ttbu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        channel_clock_tick,
  input  wire logic        external_trigger_input,
  input  wire logic        internal_trigger_zero,
  input  wire logic        debug_halt,
  output logic             update_event,
  output logic             update_irq,
  output logic      [15:0] count_out
);

  // ==========================================================================
  // synchronisers for the asynchronous tick pins
  // a level counts only once stages two and three agree, so a pin that is
  // still settling at a sample edge cannot produce a false tick
  localparam int PIN_N    = 2;
  localparam int PIN_CH   = 0;
  localparam int PIN_TRIG = 1;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_rise;
  logic             ch_rise;
  logic             trig_rise;

  assign pin_raw[PIN_CH]   = channel_clock_tick;
  assign pin_raw[PIN_TRIG] = external_trigger_input;

  generate
    for (genvar g = 0; g < PIN_N; g++)
    begin : g_pin
      logic [2:0] sync_r;
      logic       lvl_r;
      logic       agree;

      assign agree = (sync_r[1] == sync_r[2]);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_r <= 3'h0;
          lvl_r  <= 1'b0;
        end
        else
        begin
          sync_r <= {sync_r[1:0], pin_raw[g]};
          if (agree)
            lvl_r <= sync_r[2];
        end
      end

      // rising edge: agreed level high while the last agreed level was low
      assign pin_rise[g] = agree && sync_r[2] && !lvl_r;
    end
  endgenerate

  assign ch_rise   = pin_rise[PIN_CH];
  assign trig_rise = pin_rise[PIN_TRIG];

  // ==========================================================================
  // state
  ttbu_state_s s_r;
  ttbu_state_s s_nxt;

  logic                  wr_en;
  logic                  rd_en;
  logic                  sw_update;
  logic                  sw_restart;
  logic                  src_tick;
  logic                  presc_done;
  logic                  counter_tick;
  logic                  hw_update;
  logic                  wrap_evt;
  logic [TTBU_CNT_W-1:0] presc_limit;
  logic [TTBU_CNT_W-1:0] arr_eff;
  logic [31:0]           rdata;
  logic                  addr_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // event_generate_reg: update_generate is a write-only strobe, never stored
  assign sw_restart = wr_en && (paddr == TTBU_OFF_EVENT_GEN) && pwdata[TTBU_BIT_UG];
  // with updates disabled the restart still happens but raises no update event
  assign sw_update  = sw_restart && !s_r.ctrl.update_disable;

  // slave mode codes that pick the counter clock source
  localparam logic [TTBU_SMS_W-1:0] SRC_EXT_TRIG  = 3'h1;
  localparam logic [TTBU_SMS_W-1:0] SRC_TRIG_ZERO = 3'h2;
  localparam logic [TTBU_SMS_W-1:0] SRC_CH_PIN    = 3'h7;

  // counter clock source selection; debug_halt is deliberately not used, so a
  // halted core never freezes the count
  // unlisted codes fall back to the internal clock rather than stall the count
  always_comb
  begin
    case (s_r.slave_mode_select)
      TTBU_SMS_INTERNAL:
      begin
        src_tick = 1'b1;
      end
      SRC_CH_PIN:
      begin
        src_tick = ch_rise;
      end
      SRC_EXT_TRIG:
      begin
        src_tick = trig_rise;
      end
      SRC_TRIG_ZERO:
      begin
        src_tick = internal_trigger_zero;
      end
      default:
      begin
        src_tick = 1'b1;
      end
    endcase
  end

  // prescaler divides by 2**exp: limit is a mask of exp ones
  assign presc_limit  = TTBU_CNT_W'((32'h1 << s_r.prescale_work) - 32'h1);
  assign presc_done   = s_r.counter_run_sync && src_tick && (s_r.prescale_cnt == presc_limit);
  assign counter_tick = presc_done;

  // preload off: shadow tracks buffer, so the live buffer is used directly
  assign arr_eff = s_r.ctrl.reload_preload_enable ? s_r.reload_shadow : s_r.reload_buf;

  always_comb
  begin
    wrap_evt = 1'b0;
    if (counter_tick)
    begin
      if (s_r.ctrl.center_mode)
      begin
        if (s_r.ctrl.count_direction == TTBU_DIR_UP)
          // a zero reload would make reload-1 wrap to all ones
          wrap_evt = (arr_eff == TTBU_ZERO) || (s_r.count_value >= arr_eff - TTBU_ONE);
        else
          wrap_evt = (s_r.count_value <= TTBU_ONE);
      end
      else if (s_r.ctrl.count_direction == TTBU_DIR_UP)
        wrap_evt = (s_r.count_value >= arr_eff);
      else
        wrap_evt = (s_r.count_value == TTBU_ZERO);
    end
  end

  assign hw_update = wrap_evt && !s_r.ctrl.update_disable;

  // ==========================================================================
  // next state
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.pslverr = 1'b0;
    s_nxt.counter_run_sync = s_r.ctrl.counter_run_bit;

    // prescaler counter
    if (s_r.counter_run_sync && src_tick)
      s_nxt.prescale_cnt = presc_done ? TTBU_ZERO : s_r.prescale_cnt + TTBU_ONE;

    // counter motion
    if (counter_tick)
    begin
      if (s_r.ctrl.center_mode)
      begin
        if (s_r.ctrl.count_direction == TTBU_DIR_UP)
        begin
          if (wrap_evt)
          begin
            s_nxt.count_value = hw_update ? s_r.reload_buf : arr_eff;
            s_nxt.ctrl.count_direction = TTBU_DIR_DOWN;
          end
          else
            s_nxt.count_value = s_r.count_value + TTBU_ONE;
        end
        else if (wrap_evt)
        begin
          s_nxt.count_value = TTBU_ZERO;
          s_nxt.ctrl.count_direction = TTBU_DIR_UP;
        end
        else
          s_nxt.count_value = s_r.count_value - TTBU_ONE;
      end
      else if (s_r.ctrl.count_direction == TTBU_DIR_UP)
        s_nxt.count_value = wrap_evt ? TTBU_ZERO : s_r.count_value + TTBU_ONE;
      else
        // reload from the freshly updated buffer when the update coincides
        s_nxt.count_value = wrap_evt ? (hw_update ? s_r.reload_buf : arr_eff)
                                     : s_r.count_value - TTBU_ONE;
    end

    // register writes (access phase)
    if (wr_en)
    begin
      case (paddr)
        TTBU_OFF_CONTROL_ONE:
        begin
          s_nxt.ctrl.counter_run_bit       = pwdata[TTBU_BIT_RUN];
          s_nxt.ctrl.update_disable        = pwdata[TTBU_BIT_UDIS];
          s_nxt.ctrl.update_request_source = pwdata[TTBU_BIT_URS];
          s_nxt.ctrl.center_mode           = pwdata[TTBU_BIT_CMS];
          s_nxt.ctrl.reload_preload_enable = pwdata[TTBU_BIT_ARPE];
          if (!s_r.ctrl.center_mode && !pwdata[TTBU_BIT_CMS])
            s_nxt.ctrl.count_direction = ttbu_dir_e'(pwdata[TTBU_BIT_DIR]);
        end
        TTBU_OFF_FLAG:
          if (pwdata[TTBU_BIT_UFLAG])
            s_nxt.update_flag = 1'b0;
        TTBU_OFF_IRQ_EN:
        begin
          s_nxt.update_irq_en = pwdata[TTBU_BIT_UIE];
        end
        TTBU_OFF_COUNT:
        begin
          s_nxt.count_value = pwdata[TTBU_CNT_W-1:0];
        end
        TTBU_OFF_PRESCALE:
        begin
          s_nxt.prescale_buf = pwdata[TTBU_EXP_W-1:0];
        end
        TTBU_OFF_RELOAD:
        begin
          s_nxt.reload_buf = pwdata[TTBU_CNT_W-1:0];
        end
        TTBU_OFF_SLAVE_MODE:
        begin
          s_nxt.slave_mode_select = pwdata[TTBU_SMS_W-1:0];
        end
        TTBU_OFF_EVENT_GEN:  ;
        default:             s_nxt.pslverr = 1'b1;
      endcase
    end

    // software update: restart counters, keep ratio until transfer below
    if (sw_restart)
    begin
      s_nxt.prescale_cnt = TTBU_ZERO;
      if (!s_r.ctrl.center_mode && s_r.ctrl.count_direction == TTBU_DIR_DOWN)
        s_nxt.count_value = s_r.reload_buf;
      else
      begin
        s_nxt.count_value = TTBU_ZERO;
        if (s_r.ctrl.center_mode)
          s_nxt.ctrl.count_direction = TTBU_DIR_UP;
      end
    end

    // update event transfers; set beats a simultaneous flag clear
    if (hw_update || sw_update)
    begin
      s_nxt.prescale_work = s_r.prescale_buf;
      s_nxt.reload_shadow = s_r.reload_buf;
      if (hw_update || !s_r.ctrl.update_request_source)
        s_nxt.update_flag = 1'b1;
    end
    if (!s_r.ctrl.reload_preload_enable)
      s_nxt.reload_shadow = s_nxt.reload_buf;

    if (rd_en)
    begin
      s_nxt.prdata = rdata;
      s_nxt.pslverr = !addr_ok;
    end
  end

  // ==========================================================================
  // read mux, sampled in setup so prdata is a flop at the access phase
  always_comb
  begin
    rdata   = 32'h0;
    addr_ok = 1'b1;
    case (paddr)
      TTBU_OFF_CONTROL_ONE:
      begin
        rdata[TTBU_BIT_RUN]  = s_r.ctrl.counter_run_bit;
        rdata[TTBU_BIT_UDIS] = s_r.ctrl.update_disable;
        rdata[TTBU_BIT_URS]  = s_r.ctrl.update_request_source;
        rdata[TTBU_BIT_DIR]  = s_r.ctrl.count_direction;
        rdata[TTBU_BIT_CMS]  = s_r.ctrl.center_mode;
        rdata[TTBU_BIT_ARPE] = s_r.ctrl.reload_preload_enable;
      end
      TTBU_OFF_EVENT_GEN:
      begin
        rdata = 32'h0;
      end
      TTBU_OFF_FLAG:
      begin
        rdata[TTBU_BIT_UFLAG] = s_r.update_flag;
      end
      TTBU_OFF_IRQ_EN:
      begin
        rdata[TTBU_BIT_UIE] = s_r.update_irq_en;
      end
      TTBU_OFF_COUNT:
      begin
        rdata[TTBU_CNT_W-1:0] = s_r.count_value;
      end
      TTBU_OFF_PRESCALE:
      begin
        rdata[TTBU_EXP_W-1:0] = s_r.prescale_buf;
      end
      TTBU_OFF_RELOAD:
      begin
        rdata[TTBU_CNT_W-1:0] = s_r.reload_buf;
      end
      TTBU_OFF_SLAVE_MODE:
      begin
        rdata[TTBU_SMS_W-1:0] = s_r.slave_mode_select;
      end
      default:             addr_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r                   <= '0;
      s_r.reload_buf        <= TTBU_RELOAD_RST;
      s_r.reload_shadow     <= TTBU_RELOAD_RST;
      s_r.slave_mode_select <= TTBU_SMS_INTERNAL;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================================
  // outputs
  assign prdata       = s_r.prdata;
  // zero wait states: every access completes in its first access cycle
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && (s_r.pslverr || (wr_en && !addr_ok));
  // combinational, so it marks the very cycle whose edge applies the update
  assign update_event = hw_update || sw_update;
  assign update_irq   = s_r.update_flag && s_r.update_irq_en;
  assign count_out    = s_r.count_value;

endmodule : ttbu_time_base

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import ttbu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, dbg, ck_t, et_t, it_t;
  logic        pready, pslverr, update_event, update_irq;
  logic [7:0]  paddr;
  logic [15:0] count_out, v, it_cnt, c0, i0;
  logic [31:0] pwdata, prdata, lfsr, ev_cnt, e0;
  logic [32:0] e_w;
  logic [32:0] exp_q[$];
  int          bad_count, compares;

  ttbu_time_base i_ttbu_time_base (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_clock_tick(ck_t),
    .external_trigger_input(et_t), .internal_trigger_zero(it_t), .debug_halt(dbg),
    .update_event(update_event), .update_irq(update_irq), .count_out(count_out));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  always #2 pclk = ~pclk;

  // ====================
  // random pin noise and result watchers
  // slave mode stays internal until the last scenario, so pin noise must not move the counter
  always @(posedge pclk)
  begin
    lfsr <= nxt(lfsr);
    ck_t <= lfsr[3];
    et_t <= lfsr[7];
    it_t <= lfsr[11];
    if (update_event === 1'b1)
      ev_cnt <= ev_cnt + 32'h1;
    // high cycles of the trigger pin as the design samples them
    if (it_t === 1'b1)
      it_cnt <= it_cnt + 16'h1;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e_w = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1FFFFFFFF;
      chk(e_w[31:0], prdata);
      chk({31'h0, e_w[32]}, {31'h0, pslverr});
    end
  end

  task chk(input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex)
    begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, ex, got);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task irq(input logic [31:0] ex);
    @(posedge pclk);
    #1;
    chk(ex, {31'h0, update_irq});
  endtask : irq

  // windows are whole periods, so the count does not depend on phase
  task win(input int n, input logic [31:0] ex, input bit sync);
    for (int i = 0; i < 1000 && sync && update_event !== 1'b1; i++)
      @(posedge pclk);
    e0 = ev_cnt;
    repeat (n) @(posedge pclk);
    chk(ex, ev_cnt - e0);
  endtask : win

  task results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  initial
  begin
    #40000;
    bad_count++;
    results();
  end

  // ====================
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, dbg, ck_t, et_t, it_t} = 9'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lfsr = 32'h00014211;
    ev_cnt = 32'h0;
    it_cnt = 16'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(TTBU_OFF_RELOAD, 33'h00000FFFF);
    rd(TTBU_OFF_CONTROL_ONE, 33'h0);
    rd(8'h20, 33'h100000000);
    wr(8'h20, 32'hFFFFFFFF);
    v = lfsr[15:0];
    wr(TTBU_OFF_COUNT, {16'h0, v});
    rd(TTBU_OFF_COUNT, {17'h0, v});
    wr(TTBU_OFF_PRESCALE, 32'hFFFFFFFF);
    rd(TTBU_OFF_PRESCALE, 33'hF);
    wr(TTBU_OFF_PRESCALE, 32'h0);
    wr(TTBU_OFF_EVENT_GEN, 32'h1);
    rd(TTBU_OFF_COUNT, 33'h0);
    rd(TTBU_OFF_FLAG, 33'h1);
    rd(TTBU_OFF_EVENT_GEN, 33'h0);
    wr(TTBU_OFF_FLAG, 32'h1);
    rd(TTBU_OFF_FLAG, 33'h0);
    wr(TTBU_OFF_CONTROL_ONE, 32'h4);
    wr(TTBU_OFF_EVENT_GEN, 32'h1);
    rd(TTBU_OFF_FLAG, 33'h0);
    wr(TTBU_OFF_CONTROL_ONE, 32'h10);
    wr(TTBU_OFF_RELOAD, 32'h7);
    wr(TTBU_OFF_EVENT_GEN, 32'h1);
    rd(TTBU_OFF_COUNT, 33'h7);
    wr(TTBU_OFF_CONTROL_ONE, 32'h90);
    wr(TTBU_OFF_RELOAD, 32'h5);
    wr(TTBU_OFF_EVENT_GEN, 32'h1);
    rd(TTBU_OFF_COUNT, 33'h5);
    wr(TTBU_OFF_FLAG, 32'h1);
    wr(TTBU_OFF_IRQ_EN, 32'h1);
    irq(32'h0);
    wr(TTBU_OFF_CONTROL_ONE, 32'h0);
    wr(TTBU_OFF_EVENT_GEN, 32'h1);
    irq(32'h1);
    wr(TTBU_OFF_FLAG, 32'h1);
    irq(32'h0);
    wr(TTBU_OFF_RELOAD, 32'h4);
    dbg <= 1'b1;
    wr(TTBU_OFF_CONTROL_ONE, 32'h1);
    win(50, 32'd10, 1'b1);
    wr(TTBU_OFF_PRESCALE, 32'h1);
    win(50, 32'd5, 1'b1);
    wr(TTBU_OFF_PRESCALE, 32'h0);
    wr(TTBU_OFF_CONTROL_ONE, 32'h11);
    win(50, 32'd10, 1'b1);
    wr(TTBU_OFF_CONTROL_ONE, 32'h21);
    win(48, 32'd12, 1'b1);
    wr(TTBU_OFF_CONTROL_ONE, 32'h23);
    win(48, 32'd0, 1'b0);
    wr(TTBU_OFF_CONTROL_ONE, 32'h22);
    wr(TTBU_OFF_FLAG, 32'h1);
    wr(TTBU_OFF_EVENT_GEN, 32'h1);
    rd(TTBU_OFF_COUNT, 33'h0);
    rd(TTBU_OFF_FLAG, 33'h0);
    rd(TTBU_OFF_CONTROL_ONE, 33'h22);
    // internal trigger zero: one count per high cycle that the design samples
    wr(TTBU_OFF_RELOAD, 32'hFFFF);
    wr(TTBU_OFF_SLAVE_MODE, 32'h2);
    wr(TTBU_OFF_CONTROL_ONE, 32'h1);
    repeat (4) @(posedge pclk);
    c0 = count_out;
    i0 = it_cnt;
    repeat (100) @(posedge pclk);
    chk({16'h0, it_cnt - i0}, {16'h0, count_out - c0});
    results();
  end
endmodule : testbench

/* tb/ttbu_time_base_monitor.sv */
`timescale 1ns/1ns
module ttbu_mon
  import ttbu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        update_event,
  input wire logic        update_irq,
  input wire logic [15:0] count_out
);
  // ====================
  // helper logic
  logic seen_r;
  wire  acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      seen_r <= 1'b0;
    else if (update_event)
      seen_r <= 1'b1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // assertions
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr > 8'h1C |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (acc && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  a_err_setup: assert property (psel && !penable |-> !pslverr)
    else $error("error in setup");
  a_count_write: assert property (acc && pwrite && paddr == TTBU_OFF_COUNT
    |=> count_out == $past(pwdata[15:0])) else $error("count write lost");
  a_ug_zero: assert property (acc && !pwrite && paddr == TTBU_OFF_EVENT_GEN
    |-> prdata == 32'h0) else $error("generate bit reads one");
  a_bad_zero: assert property (acc && !pwrite && paddr > 8'h1C |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_quiet: assert property (!seen_r |-> !update_irq)
    else $error("irq before any update");
endmodule : ttbu_mon

bind ttbu_time_base ttbu_mon i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .update_event(update_event),
  .update_irq(update_irq), .count_out(count_out));
